// ==== logic/tfm_pkg.sv ====
package tfm_pkg;
    // Bus address: fixed upper bits plus two strap bits
    localparam logic [4:0] ADDR_UPPER  = 5'h0b;   // 01011
    localparam logic [1:0] STRAP_GND   = 2'h0;
    localparam logic [1:0] STRAP_OPEN  = 2'h2;
    localparam logic [1:0] STRAP_VCC   = 2'h1;
    localparam logic [6:0] ARA_ADDR    = 7'h0c;   // Alert response address
    // Register indices
    localparam logic [7:0] IDX_CONFIG  = 8'h00;
    localparam logic [7:0] IDX_STATUS  = 8'h02;
    localparam logic [7:0] IDX_FANDIV  = 8'h03;
    localparam logic [7:0] IDX_TLOCAL  = 8'h0a;
    localparam logic [7:0] IDX_TREMOTE = 8'h0b;
    localparam logic [7:0] IDX_FANCNT  = 8'h08;
    localparam logic [7:0] IDX_LLOCAL  = 8'h14;
    localparam logic [7:0] IDX_LREMOTE = 8'h15;
    localparam logic [7:0] IDX_LFAN    = 8'h10;
    localparam logic [7:0] PTR_RESET   = 8'h00;
    localparam logic [7:0] CONFIG_RST  = 8'h01;
    localparam logic [7:0] LIMIT_RST   = 8'hff;
    // Status bit positions
    localparam int ST_LOCAL  = 0;
    localparam int ST_REMOTE = 1;
    localparam int ST_FAN    = 2;
    // Count tick: 153 ticks per tach period at 4400 RPM and divisor 1,
    // taking one tach edge per revolution
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned NOM_RPM        = 4400;
    localparam int unsigned NOM_COUNT      = 153;
    localparam int unsigned US_PER_MIN     = 60000000;
    localparam int unsigned TICK_CYCLES    = CLK_MHZ
                                             * (US_PER_MIN / NOM_RPM)
                                             / NOM_COUNT;
    localparam logic [7:0]  FAN_COUNT_MAX  = 8'hff;
endpackage : tfm_pkg

// ==== logic/tfm_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - All configuration except the strap-set address arrives only through the two-wire bus slave.
// - First byte of a write loads the register-index pointer.
// - Pointer selects which internal register a data access reaches.
// - Status holds one violation flag per limit comparison.
// - Each measurement sits in a value register beside a writable limit.
// - Fan count is 8 bits, prescaled by divisor 1, 2, 4 or 8.
// - Alert response address returns this device's address to the host.
// - Address is 01011 plus two strap bits caught once after reset.
// - Write carries one or two bytes, read one; read uses pointer.
module tfm_regs
    import tfm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [1:0] strapLevel,
    input  wire logic       tachIn,
    input  wire logic [7:0] tempLocal,
    input  wire logic [7:0] tempRemote,
    input  wire logic       alertSrc,
    output logic            alertOut,
    output logic            alertOe,
    output logic [7:0]      config_
);
    typedef enum {S_IDLE, S_ADDR, S_ACK, S_WDATA, S_RDATA, S_RACK,
                  S_SKIP} tfm_state_e;

    // Synchronised pins
    logic sclS, sdaS, tachS;
    tfm_sync uSyncScl  (.clk(clk), .reset_n(reset_n), .din(sclIn),
                        .dout(sclS));
    tfm_sync uSyncSda  (.clk(clk), .reset_n(reset_n), .din(sdaIn),
                        .dout(sdaS));
    tfm_sync uSyncTach (.clk(clk), .reset_n(reset_n), .din(tachIn),
                        .dout(tachS));

    tfm_state_e state, next_state;
    logic       sclD, sdaD;
    logic [7:0] shift, next_shift;
    logic [3:0] bitCnt, next_bitCnt;
    logic       rnw, next_rnw;
    logic       isAra, next_isAra;
    logic       firstByte, next_firstByte;
    logic [7:0] pointer, next_pointer;
    logic [7:0] next_config;
    logic [7:0] limLocal, next_limLocal;
    logic [7:0] limRemote, next_limRemote;
    logic [7:0] limFan, next_limFan;
    logic [7:0] fanDiv, next_fanDiv;
    logic [7:0] status, next_status;
    logic [7:0] fanCount, next_fanCount;
    logic [7:0] tachAcc, next_tachAcc;
    logic [31:0] gateCnt, next_gateCnt;
    logic [3:0] prescale, next_prescale;
    logic       tachD;
    logic [6:0] myAddr, next_myAddr;
    logic       strapDone, next_strapDone;
    logic       next_sdaOut, next_sdaOe;
    logic       next_alertOut, next_alertOe;
    logic       statusRead;

    // Strap level decode; an unknown code behaves as ground
    function automatic logic [1:0] strap_bits(input logic [1:0] lvl);
        case (lvl)
            STRAP_OPEN: strap_bits = STRAP_OPEN;
            STRAP_VCC:  strap_bits = STRAP_VCC;
            default:    strap_bits = STRAP_GND;
        endcase
    endfunction : strap_bits

    // Read mux selected by the pointer
    function automatic logic [7:0] read_sel(input logic [7:0] idx);
        case (idx)
            IDX_CONFIG:  read_sel = config_;
            IDX_STATUS:  read_sel = status;
            IDX_FANDIV:  read_sel = fanDiv;
            IDX_TLOCAL:  read_sel = tempLocal;
            IDX_TREMOTE: read_sel = tempRemote;
            IDX_FANCNT:  read_sel = fanCount;
            IDX_LLOCAL:  read_sel = limLocal;
            IDX_LREMOTE: read_sel = limRemote;
            IDX_LFAN:    read_sel = limFan;
            default:     read_sel = 8'h00;
        endcase
    endfunction : read_sel

    wire sclRise = sclS & ~sclD;
    wire sclFall = ~sclS & sclD;
    wire startC  = sclS & sclD & sdaD & ~sdaS;
    wire stopC   = sclS & sclD & ~sdaD & sdaS;

    // Bus protocol engine and register writes
    always_comb begin
        next_state     = state;
        next_shift     = shift;
        next_bitCnt    = bitCnt;
        next_rnw       = rnw;
        next_isAra     = isAra;
        next_firstByte = firstByte;
        next_pointer   = pointer;
        next_config    = config_;
        next_limLocal  = limLocal;
        next_limRemote = limRemote;
        next_limFan    = limFan;
        next_fanDiv    = fanDiv;
        next_sdaOut    = 1'b0;
        next_sdaOe     = sdaOe;
        statusRead     = 1'b0;
        if (startC) begin
            next_state  = S_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOe  = 1'b0;
        end else if (stopC) begin
            next_state = S_IDLE;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                S_ADDR, S_WDATA: if (sclRise) begin
                    next_shift  = {shift[6:0], sdaS};
                    next_bitCnt = bitCnt + 4'h1;
                end else if (sclFall && bitCnt == 4'h8) begin
                    next_bitCnt = 4'h0;
                    if (state == S_ADDR) begin
                        next_rnw   = shift[0];
                        next_isAra = (shift[7:1] == ARA_ADDR)
                                     && shift[0] && alertSrc;
                        if ((shift[7:1] == myAddr) || next_isAra) begin
                            next_sdaOe     = 1'b1;     // Acknowledge
                            next_state     = S_ACK;
                            next_firstByte = 1'b1;
                        end else begin
                            next_state = S_SKIP;
                        end
                    end else if (firstByte) begin
                        next_pointer   = shift;
                        next_firstByte = 1'b0;
                        next_sdaOe     = 1'b1;
                        next_state     = S_ACK;
                    end else begin
                        // Second byte goes where the pointer says
                        case (pointer)
                            IDX_CONFIG:  next_config    = shift;
                            IDX_FANDIV:  next_fanDiv    = shift;
                            IDX_LLOCAL:  next_limLocal  = shift;
                            IDX_LREMOTE: next_limRemote = shift;
                            IDX_LFAN:    next_limFan    = shift;
                            default:     next_config    = config_;
                        endcase
                        // Further bytes are not acknowledged
                        next_state = S_SKIP;
                        next_sdaOe = 1'b1;
                        next_firstByte = 1'b1;
                    end
                end
                S_ACK: if (sclFall) begin
                    next_sdaOe = 1'b0;
                    if (next_firstByte && state == S_ACK && rnw) begin
                        // Read: ARA returns our address, else pointer data
                        next_shift  = isAra ? {myAddr, 1'b0}
                                            : read_sel(pointer);
                        if (!isAra && pointer == IDX_STATUS)
                            statusRead = 1'b1;
                        next_sdaOe  = ~next_shift[7];
                        next_bitCnt = 4'h1;
                        next_state  = S_RDATA;
                    end else begin
                        next_state = S_WDATA;
                    end
                end
                S_RDATA: if (sclFall) begin
                    if (bitCnt == 4'h8) begin
                        next_sdaOe = 1'b0;
                        next_state = S_RACK;
                    end else begin
                        next_shift  = {shift[6:0], 1'b0};
                        next_sdaOe  = ~shift[6];
                        next_bitCnt = bitCnt + 4'h1;
                    end
                end
                S_RACK: if (sclFall) begin
                    next_state = S_SKIP;       // One read byte only
                end
                S_SKIP: if (sclFall) begin
                    next_sdaOe = 1'b0;         // Release any extra ack
                end
                default: next_state = S_IDLE;
            endcase
        end
    end

    // Tach: prescaled ticks per tach period, so a slow fan reads high and a
    // larger divisor reads low; a stalled fan saturates at full scale
    always_comb begin
        next_gateCnt  = gateCnt + 32'h1;
        next_tachAcc  = tachAcc;
        next_prescale = prescale;
        next_fanCount = fanCount;
        if (gateCnt >= TICK_CYCLES - 1) begin
            next_gateCnt = 32'h0;
            if (prescale >= ((4'h1 << fanDiv[1:0]) - 4'h1)) begin
                next_prescale = 4'h0;
                if (tachAcc != FAN_COUNT_MAX)
                    next_tachAcc = tachAcc + 8'h1;
            end else begin
                next_prescale = prescale + 4'h1;
            end
        end
        if (tachS & ~tachD) begin
            next_fanCount = tachAcc;
            next_tachAcc  = 8'h00;
            next_prescale = 4'h0;
            next_gateCnt  = 32'h0;
        end else if (tachAcc == FAN_COUNT_MAX) begin
            next_fanCount = FAN_COUNT_MAX;                   // Stalled
        end
    end

    // Limit comparisons; set wins over clear-on-read
    always_comb begin
        next_status = statusRead ? 8'h00 : status;
        if (tempLocal > limLocal)   next_status[ST_LOCAL]  = 1'b1;
        if (tempRemote > limRemote) next_status[ST_REMOTE] = 1'b1;
        if (fanCount > limFan)      next_status[ST_FAN]    = 1'b1;  // Slow
        next_alertOe  = |status;       // Drive alert low on violation
        next_alertOut = 1'b0;
        next_strapDone = 1'b1;
        next_myAddr    = strapDone ? myAddr
                                   : {ADDR_UPPER, strap_bits(strapLevel)};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state     <= S_IDLE;
            sclD      <= 1'b1;
            sdaD      <= 1'b1;
            tachD     <= 1'b1;
            shift     <= 8'h00;
            bitCnt    <= 4'h0;
            rnw       <= 1'b0;
            isAra     <= 1'b0;
            firstByte <= 1'b1;
            pointer   <= PTR_RESET;
            config_   <= CONFIG_RST;
            limLocal  <= LIMIT_RST;
            limRemote <= LIMIT_RST;
            limFan    <= LIMIT_RST;
            fanDiv    <= 8'h00;
            status    <= 8'h00;
            fanCount  <= FAN_COUNT_MAX;
            tachAcc   <= 8'h00;
            gateCnt   <= 32'h0;
            prescale  <= 4'h0;
            myAddr    <= {ADDR_UPPER, STRAP_GND};
            strapDone <= 1'b0;
            sdaOut    <= 1'b0;
            sdaOe     <= 1'b0;
            alertOut  <= 1'b0;
            alertOe   <= 1'b0;
        end else begin
            state     <= next_state;
            sclD      <= sclS;
            sdaD      <= sdaS;
            tachD     <= tachS;
            shift     <= next_shift;
            bitCnt    <= next_bitCnt;
            rnw       <= next_rnw;
            isAra     <= next_isAra;
            firstByte <= next_firstByte;
            pointer   <= next_pointer;
            config_   <= next_config;
            limLocal  <= next_limLocal;
            limRemote <= next_limRemote;
            limFan    <= next_limFan;
            fanDiv    <= next_fanDiv;
            status    <= next_status;
            fanCount  <= next_fanCount;
            tachAcc   <= next_tachAcc;
            gateCnt   <= next_gateCnt;
            prescale  <= next_prescale;
            myAddr    <= next_myAddr;
            strapDone <= next_strapDone;
            sdaOut    <= next_sdaOut;
            sdaOe     <= next_sdaOe;
            alertOut  <= next_alertOut;
            alertOe   <= next_alertOe;
        end
    end
endmodule : tfm_regs

// ==== logic/tfm_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module tfm_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_dout;

    // Shift and filter
    always_comb begin
        next_stage = {stage[1:0], din};
        next_dout  = (stage[2] == stage[1]) ? stage[2] : dout;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage <= 3'h7;
            dout  <= 1'b1;
        end else begin
            stage <= next_stage;
            dout  <= next_dout;
        end
    end
endmodule : tfm_sync

// ==== verif/tb_tfm_regs.sv ====
`timescale 1ns/1ps
// Self-checking bench for the register block
module tb_tfm_regs
    import tfm_pkg::*;
;
    localparam logic [6:0] DEV = {ADDR_UPPER, STRAP_OPEN};
    logic clk, reset_n, scl, sdaLow, sdaLine, sdaOut, sdaOe, tachIn;
    logic alertSrc, alertOut, alertOe;
    logic [1:0] strapLevel;
    logic [7:0] tempLocal, tempRemote, config_, r;
    logic [3:0] k;
    int         mismatches, num_checks;

    // Pull-up on data unless either party pulls it low
    assign sdaLine = !sdaLow && (sdaOe ? sdaOut : 1'b1);

    tfm_regs u_tfm_regs (.clk(clk), .reset_n(reset_n), .sclIn(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .strapLevel(strapLevel), .tachIn(tachIn), .tempLocal(tempLocal),
        .tempRemote(tempRemote), .alertSrc(alertSrc),
        .alertOut(alertOut), .alertOe(alertOe), .config_(config_));
    tfm_smb_master u_m (.clk(clk), .sdaLine(sdaLine), .scl(scl),
        .sdaLow(sdaLow));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // One whole transaction: address, then a read byte or n write bytes
    task automatic xact(input logic [6:0] a, input logic rd, input int n,
        input logic [7:0] b0, input logic [7:0] b1,
        output logic [3:0] ack, output logic [7:0] rdat);
        logic [7:0] tx[3] = '{b0, b1, 8'h77};
        logic [7:0] junk;
        logic ak;
        ack = 4'h0;
        rdat = 8'h00;
        u_m.startBus();
        u_m.byteXfer({a, rd}, junk, ak);
        ack[0] = ak;
        if (rd) u_m.byteXfer(8'hff, rdat, ak);
        for (int i = 0; i < n && !rd; i++) begin
            u_m.byteXfer(tx[i], junk, ak);
            ack[i+1] = ak;
        end
        u_m.stopBus();
    endtask : xact
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xact(DEV, 1'b0, 2, idx, d, k, r);
        check({4'h0, k}, 8'h07, "write acks");
    endtask : wr
    // Pointer-only write, then a plain read
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        xact(DEV, 1'b0, 1, idx, 8'h00, k, r);
        check({4'h0, k}, 8'h03, "pointer acks");
        xact(DEV, 1'b1, 0, 8'h00, 8'h00, k, d);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    task automatic t_reset();
        check(config_, CONFIG_RST, "config reset");
        check({7'h00, sdaOe, alertOe}, 8'h00, "pins idle");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_write();
        wr(IDX_CONFIG, 8'h5a);
        check(config_, 8'h5a, "config write");
        xact(DEV, 1'b0, 3, IDX_CONFIG, 8'h3c, k, r);
        check({4'h0, k}, 8'h07, "third byte refused");
        check(config_, 8'h3c, "config second write");
        $display("t_write done");
    endtask : t_write
    task automatic t_pointer();
        rd(IDX_TLOCAL, r);
        check(r, 8'h2b, "local temp");
        xact(DEV, 1'b1, 0, 8'h00, 8'h00, k, r);
        check(r, 8'h2b, "reread kept pointer");
        rd(IDX_CONFIG, r);
        check(r, 8'h3c, "config read");
        rd(8'h7f, r);
        check(r, 8'h00, "unmapped read");
        $display("t_pointer done");
    endtask : t_pointer
    // Each temperature raised over its limit, flagged, then cleared
    task automatic t_status();
        wr(IDX_LFAN, LIMIT_RST);
        for (int i = 0; i < 2; i++) begin
            wr(i ? IDX_LREMOTE : IDX_LLOCAL, 8'h30);
            rd(i ? IDX_LREMOTE : IDX_LLOCAL, r);
            check(r, 8'h30, "limit readback");
            if (i) tempRemote = 8'h40;
            else tempLocal = 8'h40;
            u_m.tick(16);
            check({7'h00, alertOe}, 8'h01, "alert on");
            rd(IDX_STATUS, r);
            check(r, 8'h01 << i, "status flag");
            tempLocal = 8'h2b;
            tempRemote = 8'h1e;
            rd(IDX_STATUS, r);
            rd(IDX_STATUS, r);
            check(r, 8'h00, "status cleared");
            check({7'h00, alertOe}, 8'h00, "alert off");
        end
        $display("t_status done");
    endtask : t_status
    task automatic t_fandiv();
        for (int d = 0; d < 4; d++) begin
            wr(IDX_FANDIV, 8'(d));
            rd(IDX_FANDIV, r);
            check(r, 8'(d), "divisor code");
        end
        $display("t_fandiv done");
    endtask : t_fandiv
    // Unmeasured fan reads full scale; two quick tach edges read zero
    task automatic t_fan();
        rd(IDX_FANCNT, r);
        check(r, FAN_COUNT_MAX, "stalled fan count");
        wr(IDX_LFAN, 8'hfe);
        rd(IDX_STATUS, r);
        check(r, 8'h04, "fan flag");
        wr(IDX_LFAN, LIMIT_RST);
        rd(IDX_STATUS, r);
        repeat (2) begin
            tachIn = 1'b1;
            u_m.tick(8);
            tachIn = 1'b0;
            u_m.tick(8);
        end
        rd(IDX_FANCNT, r);
        check(r, 8'h00, "fast fan count");
        rd(IDX_STATUS, r);
        check(r, 8'h00, "fan flag cleared");
        $display("t_fan done");
    endtask : t_fan
    task automatic t_addr();
        strapLevel = STRAP_VCC;
        xact({ADDR_UPPER, STRAP_GND}, 1'b1, 0, 8'h00, 8'h00, k, r);
        check({7'h00, k[0]}, 8'h00, "other address");
        xact({ADDR_UPPER, STRAP_VCC}, 1'b1, 0, 8'h00, 8'h00, k, r);
        check({7'h00, k[0]}, 8'h00, "late strap ignored");
        rd(IDX_CONFIG, r);
        check(r, 8'h3c, "power-up address kept");
        $display("t_addr done");
    endtask : t_addr
    task automatic t_ara();
        alertSrc = 1'b1;
        xact(ARA_ADDR, 1'b1, 0, 8'h00, 8'h00, k, r);
        check({7'h00, k[0]}, 8'h01, "alert address ack");
        check(r, {DEV, 1'b0}, "alert answer");
        alertSrc = 1'b0;
        xact(ARA_ADDR, 1'b1, 0, 8'h00, 8'h00, k, r);
        check({7'h00, k[0]}, 8'h00, "no alert no answer");
        $display("t_ara done");
    endtask : t_ara

    initial begin
        reset_n = 1'b0;
        strapLevel = STRAP_OPEN;
        tachIn = 1'b0;
        tempLocal = 8'h2b;
        tempRemote = 8'h1e;
        alertSrc = 1'b0;
        u_m.tick(5);
        reset_n = 1'b1;
        u_m.tick(8);
        t_reset();
        t_write();
        t_pointer();
        t_status();
        t_fandiv();
        t_fan();
        t_addr();
        t_ara();
        results();
    end
    // Hang guard: the full run needs well under this many cycles
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end
endmodule : tb_tfm_regs

// ==== verif/tfm_regs_sva.sv ====
`timescale 1ns/1ps
// Pin-level watcher for the register block
module tfm_regs_sva
    import tfm_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic [1:0] strapLevel,
    input wire logic       tachIn,
    input wire logic [7:0] tempLocal,
    input wire logic [7:0] tempRemote,
    input wire logic       alertSrc,
    input wire logic       alertOut,
    input wire logic       alertOe,
    input wire logic [7:0] config_
);
    logic [6:0] sclHighCnt;
    logic [6:0] next_sclHighCnt;

    // Run of SCL high samples; saturates so a long idle never wraps
    always_comb begin
        next_sclHighCnt = sclHighCnt;
        if (!sclIn) begin
            next_sclHighCnt = 7'h00;
        end else if (sclHighCnt != 7'h7f) begin
            next_sclHighCnt = sclHighCnt + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        sclHighCnt <= reset_n ? next_sclHighCnt : 7'h00;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Sync stages mean a drive change trails the SCL fall by cycles
    sequence sclLowSettled;
        !$past(sclIn, 1) && !$past(sclIn, 3);
    endsequence
    sequence ackHeld;
        sdaOe [*8];
    endsequence

    AST_SDA_OPEN_DRAIN: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    AST_ALERT_OPEN_DRAIN: assert property (alertOut == 1'b0)
        else $error("alert pin driven high");
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !reset_n |=> config_ == CONFIG_RST && !sdaOe && !alertOe)
        else $error("reset state wrong");
    AST_DRIVE_AFTER_FALL: assert property (
        $rose(sdaOe) |-> sclLowSettled)
        else $error("data drive began outside clock low");
    AST_RELEASE_AFTER_FALL: assert property (
        $fell(sdaOe) |-> sclLowSettled)
        else $error("data release outside clock low");
    AST_DRIVE_HOLD: assert property ($rose(sdaOe) |=> ackHeld)
        else $error("data drive too short");
    AST_STABLE_CLK_HIGH: assert property (
        sclHighCnt >= 7'h08 |-> $stable(sdaOe))
        else $error("data changed while clock high");
    AST_IDLE_RELEASED: assert property (sclHighCnt >= 7'h40 |-> !sdaOe)
        else $error("data held low on idle bus");
    AST_CONFIG_QUIET: assert property (
        sclHighCnt >= 7'h40 |-> $stable(config_))
        else $error("configuration changed without bus traffic");
endmodule : tfm_regs_sva

bind tfm_regs tfm_regs_sva u_tfm_regs_sva (.clk(clk), .reset_n(reset_n),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .strapLevel(strapLevel), .tachIn(tachIn), .tempLocal(tempLocal),
    .tempRemote(tempRemote), .alertSrc(alertSrc), .alertOut(alertOut),
    .alertOe(alertOe), .config_(config_));

// ==== verif/tfm_smb_master.sv ====
`timescale 1ns/1ps
// Bus master model: owns SCL, open-drain data, never stretches
module tfm_smb_master (
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaLow
);
    localparam int HALF = 24;

    // Idle bus: both lines left to their pull-ups
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end
    // Move just after an edge so the device never races the model
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic startBus();
        sdaLow = 1'b1;
        tick(HALF);
        scl = 1'b0;
        tick(HALF / 2);
    endtask : startBus
    // Data set mid-low, sampled at the end of the high phase
    task automatic bitXfer(input logic b, output logic got);
        sdaLow = !b;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        got = sdaLine;
        scl = 1'b0;
        tick(HALF / 2);
    endtask : bitXfer
    // MSB first; ninth bit released, so a read ends in no-acknowledge
    task automatic byteXfer(input logic [7:0] tx, output logic [7:0] rx,
                            output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(tx[i], b);
            rx[i] = b;
        end
        bitXfer(1'b1, b);
        ack = !b;
    endtask : byteXfer
    task automatic stopBus();
        sdaLow = 1'b1;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sdaLow = 1'b0;
        tick(HALF);
    endtask : stopBus
endmodule : tfm_smb_master
